// ### hdl/mbf_blend.v
// Purpose: Colour converter and superimposer for one pixel
// Assumes: 16 bpp is RGB565, 24 bpp is RGB888 in bits 23:0
// Notes: Result is registered, one cycle after inputs
`timescale 1ns/1ps
`include "mbf_defines.vh"
module mbf_blend (
  input wire core_clk_i,
  input wire rst_b_i,
  input wire [3:0] mode_i,
  input wire bpp24_i,
  input wire [8:0] ratio_i,
  input wire [31:0] bg_i,
  input wire bit_i,
  input wire [23:0] one_col_i,
  input wire [23:0] zero_col_i,
  input wire [23:0] font_col_i,
  output reg [31:0] pix_o
);
  function [23:0] expand565;
    input [15:0] p;
    begin
      expand565 = {p[15:11], p[15:13], p[10:5], p[10:9], p[4:0], p[4:2]};
    end
  endfunction

  function [15:0] pack565;
    input [23:0] c;
    begin
      pack565 = {c[23:19], c[15:10], c[7:3]};
    end
  endfunction

  // Ratio 256 is full overlay, so 0 and 100% are exact
  function [7:0] mix_ch;
    input [7:0] ov;
    input [7:0] bg;
    input [8:0] r;
    reg [17:0] sum;
    begin
      sum = ov * r + bg * (`MBF_RATIO_FULL - r);
      mix_ch = sum[15:8];
    end
  endfunction

  wire is_font = (mode_i == `MBF_MODE_FONT);
  // R1: 16 bpp only outside font draw; R4: font draw may use 24 bpp
  wire wide = is_font & bpp24_i;
  wire [23:0] bg24 = wide ? bg_i[23:0] : expand565(bg_i[15:0]);
  // R3: invert overlay bit before conversion
  wire mbit = (mode_i == `MBF_MODE_MINV) ? ~bit_i : bit_i;
  // R4: zero bits in font draw leave the background untouched
  wire [8:0] r_eff = (is_font & ~mbit) ? 9'h000 : ratio_i;
  // R9: colour converter stage
  wire [23:0] ov24 = is_font ? font_col_i : (mbit ? one_col_i : zero_col_i);
  reg [23:0] mix;
  integer i;

  // R11: per-channel weighted sum
  always @* begin
    mix = 24'h000000;
    for (i = 0; i < 3; i = i + 1) begin
      mix[i*8 +: 8] = mix_ch(ov24[i*8 +: 8], bg24[i*8 +: 8], r_eff);
    end
  end

  always @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pix_o <= 32'h00000000;
    end else begin
      pix_o <= wide ? {8'h00, mix} : {16'h0000, pack565(mix)};
    end
  end
endmodule // mbf_blend

// ### hdl/mbf_defines.vh
// Purpose: Constants for the mono blend / font draw pixel engine
// Assumes: APB slave with 32-bit data, byte offsets in paddr[7:0]
// Notes: One aligned word per register
// What this block does
// R1: Mono blend mixes a 16 bpp background with a colour-converted overlay bit.
// R2: Software must feed monochrome data on the overlay source in mono blend.
// R3: Mono invert blend is mono blend with each overlay bit inverted first.
// R4: Font draw mixes a 16/24 bpp background; only overlay 1 bits are drawn.
// R5: Software programs font colour as 8-bit R, G, B with red equal blue.
// R6: Font draw rotates the blended result, so font and background turn together.
// R7: Output supports plain, thinned-out and rotated transfer in all three modes.
// R8: Background and overlay images read from internal or external RAM.
// R9: Colour converter and superimposer used; area filter idle; no scaling expander.
// R10: White fonts via mono blend: 1 to white at full ratio, fails on white.
// R11: Each channel is a ratio-weighted sum of background and overlay.
`ifndef MBF_DEFINES_VH
`define MBF_DEFINES_VH

`define MBF_OFF_CTRL 8'h00
`define MBF_OFF_RATIO 8'h04
`define MBF_OFF_FONT 8'h08
`define MBF_OFF_ONE 8'h0c
`define MBF_OFF_ZERO 8'h10
`define MBF_OFF_SIZE 8'h14
`define MBF_OFF_BGBASE 8'h18
`define MBF_OFF_OVBASE 8'h1c
`define MBF_OFF_DSTBASE 8'h20
`define MBF_OFF_STATUS 8'h24
`define MBF_OFF_STRIDE 8'h28

`define MBF_MODE_MONO 4'h6
`define MBF_MODE_MINV 4'h7
`define MBF_MODE_FONT 4'h8

`define MBF_CTRL_START 4
`define MBF_CTRL_BPP24 5
`define MBF_CTRL_THIN 6
`define MBF_CTRL_ROT 7
`define MBF_CTRL_BGEXT 12
`define MBF_CTRL_OVEXT 13

`define MBF_ST_BUSY 0
`define MBF_ST_DONE 1
`define MBF_ST_ERR 2

`define MBF_RATIO_FULL 9'h100
`define MBF_RST_RATIO 9'h000
`define MBF_RST_STEP 4'h1
`define MBF_RST_COL 24'h000000

`endif

// ### hdl/mbf_top.v
// Purpose: Mono blend, mono invert blend and font draw pixel engine
// Assumes: One outstanding read and one write at a time, req held to ack
// Notes: Overlay bit k of a byte is pixel k of the group of eight
`timescale 1ns/1ps
`include "mbf_defines.vh"
module mbf_top (
  input wire core_clk_i,
  input wire rst_b_i,
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [7:0] paddr_i,
  input wire [31:0] pwdata_i,
  output reg [31:0] prdata_o,
  output reg pready_o,
  output reg pslverr_o,
  output reg rd_req_o,
  output reg [31:0] bg_addr_o,
  output reg [31:0] ov_addr_o,
  output reg bg_ext_o,
  output reg ov_ext_o,
  input wire rd_ack_i,
  input wire [31:0] bg_data_i,
  input wire [7:0] ov_byte_i,
  output reg wr_req_o,
  output reg [31:0] wr_addr_o,
  output reg [31:0] wr_data_o,
  input wire wr_ack_i
);
  localparam ST_IDLE = 3'd0;
  localparam ST_PICK = 3'd1;
  localparam ST_READ = 3'd2;
  localparam ST_CALC = 3'd3;
  localparam ST_WRITE = 3'd4;
  localparam ST_MIX = 3'd5;

  reg [15:0] ctrl_reg;
  reg [8:0] ratio_reg;
  reg [23:0] font_reg;
  reg [23:0] one_reg;
  reg [23:0] zero_reg;
  reg [27:0] size_reg;
  reg [31:0] bgbase_reg;
  reg [31:0] ovbase_reg;
  reg [31:0] dstbase_reg;
  reg [11:0] stride_reg;
  reg done_reg;
  reg err_reg;
  reg [2:0] state_reg;
  reg [11:0] x_reg;
  reg [11:0] y_reg;
  reg [11:0] dx_reg;
  reg [11:0] dy_reg;
  reg [3:0] xm_reg;
  reg [3:0] ym_reg;
  reg [31:0] bg_hold_reg;
  reg bit_hold_reg;
  wire [31:0] blend_pix;

  wire [3:0] mode = ctrl_reg[3:0];
  wire [3:0] step = (ctrl_reg[11:8] == 4'h0) ? 4'h1 : ctrl_reg[11:8];
  wire [11:0] width = size_reg[11:0];
  wire [11:0] height = size_reg[27:16];
  wire wide = (mode == `MBF_MODE_FONT) & ctrl_reg[`MBF_CTRL_BPP24];
  wire acc = psel_i & penable_i;
  wire wr_take = acc & pready_o & pwrite_i;
  wire start = wr_take & (paddr_i == `MBF_OFF_CTRL) & pwdata_i[`MBF_CTRL_START];
  // R9: only the three modes here are accepted, no expander or filter path
  wire mode_ok = (pwdata_i[3:0] == `MBF_MODE_MONO) | (pwdata_i[3:0] == `MBF_MODE_MINV) |
                 (pwdata_i[3:0] == `MBF_MODE_FONT);

  function mapped;
    input [7:0] a;
    begin
      mapped = (a[1:0] == 2'b00) && (a <= `MBF_OFF_STRIDE);
    end
  endfunction

  // Pixel index arithmetic
  wire [23:0] src_idx = y_reg * width + {12'h000, x_reg};
  wire [23:0] dst_lin = dy_reg * stride_reg + {12'h000, dx_reg};
  wire [11:0] rot_col = stride_reg - 12'h001 - dy_reg;
  wire [23:0] dst_rot = dx_reg * stride_reg + {12'h000, rot_col};
  // R6: rotation is applied to write addresses of the blended pixel
  wire [23:0] dst_idx = ctrl_reg[`MBF_CTRL_ROT] ? dst_rot : dst_lin;
  wire [31:0] bg_off = wide ? {6'h00, src_idx, 2'b00} : {7'h00, src_idx, 1'b0};
  wire [31:0] dst_off = wide ? {6'h00, dst_idx, 2'b00} : {7'h00, dst_idx, 1'b0};
  // R7: thinning keeps every step-th pixel of every step-th line
  wire keep = ~ctrl_reg[`MBF_CTRL_THIN] | ((xm_reg == 4'h0) & (ym_reg == 4'h0));
  wire last_x = (x_reg == width - 12'h001);
  wire row_kept = ~ctrl_reg[`MBF_CTRL_THIN] | (ym_reg == 4'h0);

  // APB slave: ready one cycle into the access phase
  always @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o <= 32'h00000000;
    end else begin
      pready_o <= acc & ~pready_o;
      pslverr_o <= acc & ~pready_o & ~mapped(paddr_i);
      if (acc & ~pready_o & ~pwrite_i) begin
        case (paddr_i)
          `MBF_OFF_CTRL: prdata_o <= {16'h0000, ctrl_reg};
          `MBF_OFF_RATIO: prdata_o <= {23'h000000, ratio_reg};
          `MBF_OFF_FONT: prdata_o <= {8'h00, font_reg};
          `MBF_OFF_ONE: prdata_o <= {8'h00, one_reg};
          `MBF_OFF_ZERO: prdata_o <= {8'h00, zero_reg};
          `MBF_OFF_SIZE: prdata_o <= {4'h0, size_reg};
          `MBF_OFF_BGBASE: prdata_o <= bgbase_reg;
          `MBF_OFF_OVBASE: prdata_o <= ovbase_reg;
          `MBF_OFF_DSTBASE: prdata_o <= dstbase_reg;
          `MBF_OFF_STATUS: prdata_o <= {29'h00000000, err_reg, done_reg, state_reg != ST_IDLE};
          `MBF_OFF_STRIDE: prdata_o <= {20'h00000, stride_reg};
          default: prdata_o <= 32'h00000000;
        endcase
      end
    end
  end

  // Configuration is frozen while a frame runs
  always @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ctrl_reg <= {4'h0, `MBF_RST_STEP, 4'h0, `MBF_MODE_MONO};
      ratio_reg <= `MBF_RST_RATIO;
      font_reg <= `MBF_RST_COL;
      one_reg <= `MBF_RST_COL;
      zero_reg <= `MBF_RST_COL;
      size_reg <= 28'h0000000;
      bgbase_reg <= 32'h00000000;
      ovbase_reg <= 32'h00000000;
      dstbase_reg <= 32'h00000000;
      stride_reg <= 12'h000;
    end else if (wr_take & (state_reg == ST_IDLE)) begin
      case (paddr_i)
        `MBF_OFF_CTRL: begin
          if (mode_ok) begin
            ctrl_reg <= {2'b00, pwdata_i[13:5], 1'b0, pwdata_i[3:0]};
          end
        end
        `MBF_OFF_RATIO: ratio_reg <= (pwdata_i[8:0] > `MBF_RATIO_FULL) ? `MBF_RATIO_FULL : pwdata_i[8:0];
        // R5: red and blue levels are stored as written
        `MBF_OFF_FONT: font_reg <= pwdata_i[23:0];
        `MBF_OFF_ONE: one_reg <= pwdata_i[23:0];
        `MBF_OFF_ZERO: zero_reg <= pwdata_i[23:0];
        `MBF_OFF_SIZE: size_reg <= {pwdata_i[27:16], 4'h0, pwdata_i[11:0]};
        `MBF_OFF_BGBASE: bgbase_reg <= pwdata_i;
        `MBF_OFF_OVBASE: ovbase_reg <= pwdata_i;
        `MBF_OFF_DSTBASE: dstbase_reg <= pwdata_i;
        `MBF_OFF_STRIDE: stride_reg <= pwdata_i[11:0];
        default: stride_reg <= stride_reg;
      endcase
    end
  end

  // Done and error are write-1-to-clear; a same-cycle set wins
  always @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      done_reg <= 1'b0;
      err_reg <= 1'b0;
    end else begin
      if ((state_reg == ST_PICK) & (y_reg >= height)) begin
        done_reg <= 1'b1;
      end else if (wr_take & (paddr_i == `MBF_OFF_STATUS) & pwdata_i[`MBF_ST_DONE]) begin
        done_reg <= 1'b0;
      end
      // R9: a request for another mode is refused and flagged
      if (wr_take & (paddr_i == `MBF_OFF_CTRL) & ~mode_ok) begin
        err_reg <= 1'b1;
      end else if (wr_take & (paddr_i == `MBF_OFF_STATUS) & pwdata_i[`MBF_ST_ERR]) begin
        err_reg <= 1'b0;
      end
    end
  end

  // Frame walker
  always @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_reg <= ST_IDLE;
      x_reg <= 12'h000;
      y_reg <= 12'h000;
      dx_reg <= 12'h000;
      dy_reg <= 12'h000;
      xm_reg <= 4'h0;
      ym_reg <= 4'h0;
      rd_req_o <= 1'b0;
      bg_addr_o <= 32'h00000000;
      ov_addr_o <= 32'h00000000;
      bg_ext_o <= 1'b0;
      ov_ext_o <= 1'b0;
      wr_req_o <= 1'b0;
      wr_addr_o <= 32'h00000000;
      wr_data_o <= 32'h00000000;
      bg_hold_reg <= 32'h00000000;
      bit_hold_reg <= 1'b0;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (start & mode_ok & (state_reg == ST_IDLE)) begin
            x_reg <= 12'h000;
            y_reg <= 12'h000;
            dx_reg <= 12'h000;
            dy_reg <= 12'h000;
            xm_reg <= 4'h0;
            ym_reg <= 4'h0;
            state_reg <= ST_PICK;
          end
        end
        ST_PICK: begin
          if ((y_reg >= height) | (width == 12'h000)) begin
            state_reg <= ST_IDLE;
          end else if (keep) begin
            // R8: each source names its own RAM
            rd_req_o <= 1'b1;
            bg_addr_o <= bgbase_reg + bg_off;
            ov_addr_o <= ovbase_reg + {11'h000, src_idx[23:3]};
            bg_ext_o <= ctrl_reg[`MBF_CTRL_BGEXT];
            ov_ext_o <= ctrl_reg[`MBF_CTRL_OVEXT];
            state_reg <= ST_READ;
          end else begin
            state_reg <= ST_WRITE;
          end
        end
        ST_READ: begin
          if (rd_ack_i) begin
            rd_req_o <= 1'b0;
            bg_hold_reg <= bg_data_i;
            bit_hold_reg <= ov_byte_i[src_idx[2:0]];
            state_reg <= ST_MIX;
          end
        end
        // Blend output is registered; raising the write earlier would expose stale data
        ST_MIX: state_reg <= ST_CALC;
        ST_CALC: begin
          if (~wr_req_o) begin
            wr_req_o <= 1'b1;
            wr_addr_o <= dstbase_reg + dst_off;
            wr_data_o <= blend_pix;
          end else if (wr_ack_i) begin
            wr_req_o <= 1'b0;
            state_reg <= ST_WRITE;
          end
        end
        ST_WRITE: begin
          // Advance source and destination position
          if (keep) begin
            dx_reg <= dx_reg + 12'h001;
          end
          xm_reg <= (xm_reg == step - 4'h1) ? 4'h0 : xm_reg + 4'h1;
          if (last_x) begin
            x_reg <= 12'h000;
            xm_reg <= 4'h0;
            dx_reg <= 12'h000;
            y_reg <= y_reg + 12'h001;
            ym_reg <= (ym_reg == step - 4'h1) ? 4'h0 : ym_reg + 4'h1;
            if (row_kept) begin
              dy_reg <= dy_reg + 12'h001;
            end
          end else begin
            x_reg <= x_reg + 12'h001;
          end
          state_reg <= ST_PICK;
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // R1: background and converted overlay meet in the superimposer
  mbf_blend u_blend (
    .core_clk_i(core_clk_i),
    .rst_b_i(rst_b_i),
    .mode_i(mode),
    .bpp24_i(ctrl_reg[`MBF_CTRL_BPP24]),
    .ratio_i(ratio_reg),
    .bg_i(bg_hold_reg),
    .bit_i(bit_hold_reg),
    .one_col_i(one_reg),
    .zero_col_i(zero_reg),
    .font_col_i(font_reg),
    .pix_o(blend_pix)
  );
endmodule // mbf_top

// ### verification/mbf_mem_model.sv
// Purpose: System memory partner for the pixel engine
// Assumes: One read and one write outstanding at most
// Notes: Stale data lines are scrambled every cycle
`timescale 1ns/1ps
module mbf_mem_model (
  input logic core_clk_i,
  input logic rst_b_i,
  input logic [3:0] lat_i,
  input logic [7:0] ov_pat_i,
  input logic rd_req_i,
  input logic [31:0] bg_addr_i,
  input logic bg_ext_i,
  input logic ov_ext_i,
  input logic wr_req_i,
  input logic [31:0] wr_addr_i,
  input logic [31:0] wr_data_i,
  output logic rd_ack_o,
  output logic [31:0] bg_data_o,
  output logic [7:0] ov_byte_o,
  output logic wr_ack_o
);
  int cnt;
  logic [31:0] wa[$];
  logic [31:0] wd[$];
  logic [1:0] ext_last;
  always @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cnt <= 0;
      rd_ack_o <= 1'b0;
      wr_ack_o <= 1'b0;
      bg_data_o <= 32'h0;
      ov_byte_o <= 8'h0;
      ext_last <= 2'b00;
    end else begin
      rd_ack_o <= 1'b0;
      wr_ack_o <= 1'b0;
      bg_data_o <= ~bg_data_o;
      ov_byte_o <= ~ov_byte_o;
      if (wr_req_i && wr_ack_o) begin
        wa.push_back(wr_addr_i);
        wd.push_back(wr_data_i);
      end
      if ((rd_req_i && !rd_ack_o) || (wr_req_i && !wr_ack_o)) begin
        cnt <= cnt + 1;
        if (cnt >= lat_i) begin
          cnt <= 0;
          if (rd_req_i) begin
            rd_ack_o <= 1'b1;
            bg_data_o <= 32'h00a5c396 + bg_addr_i;
            ov_byte_o <= ov_pat_i;
            ext_last <= {bg_ext_i, ov_ext_i};
          end else begin
            wr_ack_o <= 1'b1;
          end
        end
      end
    end
  end
endmodule // mbf_mem_model

// ### verification/mbf_top_monitor.sv
// Purpose: Port checker for the mono blend and font pixel engine
// Assumes: One clock, asynchronous active-low reset
// Notes: Handshake timing and APB error responses; pixel values are judged by the bench
`timescale 1ns/1ps
module mbf_top_monitor (
  input logic core_clk_i,
  input logic rst_b_i,
  input logic psel_i,
  input logic penable_i,
  input logic pwrite_i,
  input logic [7:0] paddr_i,
  input logic [31:0] prdata_o,
  input logic pready_o,
  input logic pslverr_o,
  input logic rd_req_o,
  input logic [31:0] bg_addr_o,
  input logic [31:0] ov_addr_o,
  input logic rd_ack_i,
  input logic wr_req_o,
  input logic [31:0] wr_addr_o,
  input logic [31:0] wr_data_o,
  input logic wr_ack_i
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_b_i);
  AST_APB_WAIT: assert property (psel_i && penable_i && !$past(penable_i) |-> !pready_o ##1 pready_o)
    else $error("pready not in second access cycle");
  AST_READY_PULSE: assert property (pready_o |=> !pready_o)
    else $error("pready longer than one cycle");
  AST_ERR_UNMAPPED: assert property (pready_o && !pwrite_i && (paddr_i > 8'h28 || paddr_i[1:0] != 2'b00)
    |-> pslverr_o && prdata_o == 32'h0) else $error("unmapped read not refused");
  AST_ERR_MAPPED: assert property (pready_o && paddr_i <= 8'h28 && paddr_i[1:0] == 2'b00 |-> !pslverr_o)
    else $error("mapped access refused");
  AST_RD_HOLD: assert property (rd_req_o && !rd_ack_i |=> rd_req_o && $stable(bg_addr_o) && $stable(ov_addr_o))
    else $error("read request dropped or moved");
  AST_RD_DROP: assert property (rd_req_o && rd_ack_i |=> !rd_req_o)
    else $error("read request kept after ack");
  AST_WR_HOLD: assert property (wr_req_o && !wr_ack_i |=> wr_req_o && $stable({wr_addr_o, wr_data_o}))
    else $error("write request dropped or moved");
  AST_WR_GAP: assert property (wr_req_o && wr_ack_i |=> !wr_req_o [*3])
    else $error("writes closer than four cycles");
  AST_RD_TO_WR: assert property (rd_req_o && rd_ack_i |-> ##[1:4] wr_req_o)
    else $error("no result write after pixel read");
  cover property (rd_req_o && rd_ack_i);
  cover property (wr_req_o && wr_ack_i);
  cover property (pslverr_o);
endmodule // mbf_top_monitor

// ### verification/test_mbf_top.sv
// Purpose: Self-checking bench for the pixel engine
// Assumes: Partner memory answers after lat cycles
// Notes: One row of eight pixels per frame
`timescale 1ns/1ps
`include "mbf_defines.vh"
module test_mbf_top;
  logic core_clk_i, rst_b_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o;
  logic rd_req_o, bg_ext_o, ov_ext_o, rd_ack_i, wr_req_o, wr_ack_i;
  logic [7:0] paddr_i, ov_byte_i, ovp;
  logic [31:0] pwdata_i, prdata_o, bg_addr_o, ov_addr_o, bg_data_i, wr_addr_o, wr_data_o;
  logic [3:0] lat;
  int checks, miscompares, cyc;
  mbf_top i_mbf_top (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .rd_req_o(rd_req_o), .bg_addr_o(bg_addr_o), .ov_addr_o(ov_addr_o),
    .bg_ext_o(bg_ext_o), .ov_ext_o(ov_ext_o), .rd_ack_i(rd_ack_i), .bg_data_i(bg_data_i),
    .ov_byte_i(ov_byte_i), .wr_req_o(wr_req_o), .wr_addr_o(wr_addr_o), .wr_data_o(wr_data_o), .wr_ack_i(wr_ack_i));
  mbf_mem_model i_mem (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .lat_i(lat), .ov_pat_i(ovp),
    .rd_req_i(rd_req_o), .bg_addr_i(bg_addr_o), .bg_ext_i(bg_ext_o), .ov_ext_i(ov_ext_o), .wr_req_i(wr_req_o),
    .wr_addr_i(wr_addr_o), .wr_data_i(wr_data_o), .rd_ack_o(rd_ack_i), .bg_data_o(bg_data_i),
    .ov_byte_o(ov_byte_i), .wr_ack_o(wr_ack_i));
  initial begin
    core_clk_i = 1'b0;
    forever #25 core_clk_i = ~core_clk_i;
  end
  task results;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // Ceiling well above the thousand or so cycles the tests take
  always @(posedge core_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      miscompares++;
      results();
    end
  end
  task chk(input logic [31:0] g, input logic [31:0] x, input string m);
    checks++;
    if (g !== x) begin
      miscompares++;
      $display("[FAIL] %0t %s got %h exp %h", $time, m, g, x);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q, output logic e);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge core_clk_i);
    penable_i <= 1'b1;
    // No assumed latency; only the cycle ceiling ends a hang
    @(posedge core_clk_i);
    while (pready_o !== 1'b1) @(posedge core_clk_i);
    q = prdata_o;
    e = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    @(posedge core_clk_i);
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] x, input logic xe);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h0, q, e);
    chk(q, x, "read data");
    chk({31'h0, e}, {31'h0, xe}, "slverr");
  endtask
  function automatic logic [23:0] mix(input logic [23:0] f, input logic [23:0] g, input int r);
    for (int c = 0; c < 24; c += 8) mix[c+:8] = 8'((f[c+:8] * r + g[c+:8] * (256 - r)) >> 8);
  endfunction
  // Runs one frame and compares every written pixel
  task frame(input logic [31:0] ctrl, input int r, input logic inv, input logic font, input logic rot, input int st);
    logic [31:0] q, bg, ex;
    logic e, b;
    int n;
    n = 0;
    q = 32'h0;
    i_mem.wa.delete();
    i_mem.wd.delete();
    wr(`MBF_OFF_RATIO, r);
    wr(`MBF_OFF_CTRL, ctrl);
    while (q[1] !== 1'b1 && n < 300) begin
      apb(1'b0, `MBF_OFF_STATUS, 32'h0, q, e);
      n++;
    end
    wr(`MBF_OFF_STATUS, 32'h2);
    chk(i_mem.wa.size(), 8 / st, "pixel count");
    for (int k = 0; k < 8 / st; k++) begin
      b = ovp[k * st] ^ inv;
      bg = 32'h00a5c396 + 32'h1000 + 4 * k * st;
      ex = font ? (b ? mix(24'h40c040, bg[23:0], r) : bg[23:0]) : (b ? 32'hffff : 32'h0);
      chk(i_mem.wa[k], 32'h3000 + (rot ? 4 * (4 * k + 3) : (font ? 4 : 2) * k), "dst addr");
      chk(i_mem.wd[k] & (font ? 32'hffffff : 32'hffff), ex, "pixel");
    end
    $display("frame ctrl %h done", ctrl);
  endtask
  initial begin
    {psel_i, penable_i, pwrite_i, paddr_i, pwdata_i, checks, miscompares, cyc} = '0;
    rst_b_i = 1'b0;
    lat = 4'h0;
    ovp = 8'ha5;
    repeat (3) @(posedge core_clk_i);
    rst_b_i <= 1'b1;
    @(posedge core_clk_i);
    rd(`MBF_OFF_CTRL, 32'h106, 1'b0);
    rd(`MBF_OFF_RATIO, 32'h0, 1'b0);
    rd(8'h2c, 32'h0, 1'b1);
    rd(8'h06, 32'h0, 1'b1);
    $display("reset and decode test done");
    wr(`MBF_OFF_SIZE, 32'h00010008);
    wr(`MBF_OFF_BGBASE, 32'h1000);
    wr(`MBF_OFF_OVBASE, 32'h2000);
    wr(`MBF_OFF_DSTBASE, 32'h3000);
    wr(`MBF_OFF_STRIDE, 32'h4);
    wr(`MBF_OFF_ONE, 32'hffffff);
    wr(`MBF_OFF_ZERO, 32'h0);
    wr(`MBF_OFF_FONT, 32'h40c040);
    frame(32'h116, 256, 1'b0, 1'b0, 1'b0, 1);
    lat <= 4'h5;
    frame(32'h117, 256, 1'b1, 1'b0, 1'b0, 1);
    frame(32'h256, 256, 1'b0, 1'b0, 1'b0, 2);
    frame(32'h3138, 256, 1'b0, 1'b1, 1'b0, 1);
    chk(i_mem.ext_last, 2'b11, "external select");
    ovp <= 8'h3c;
    frame(32'h1b8, 128, 1'b0, 1'b1, 1'b1, 1);
    wr(`MBF_OFF_CTRL, 32'h115);
    rd(`MBF_OFF_STATUS, 32'h4, 1'b0);
    $display("bad mode test done");
    results();
  end
endmodule // test_mbf_top
bind mbf_top mbf_top_monitor i_mon (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .psel_i(psel_i),
  .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .prdata_o(prdata_o), .pready_o(pready_o),
  .pslverr_o(pslverr_o), .rd_req_o(rd_req_o), .bg_addr_o(bg_addr_o), .ov_addr_o(ov_addr_o), .rd_ack_i(rd_ack_i),
  .wr_req_o(wr_req_o), .wr_addr_o(wr_addr_o), .wr_data_o(wr_data_o), .wr_ack_i(wr_ack_i));
